// [rtl/dcc_top.sv]
// Operation
// RULE_01: Three-bit mode field in control bits 2-0 selects one of eight setups.
// RULE_02: Bit 7 shows comparator B result, inverted when its invert bit is set.
// RULE_03: Bit 6 shows comparator A result, inverted when its invert bit is set.
// RULE_04: Bits 5 and 4 invert B and A on result bits and pins.
// RULE_05: In mode 110 the switch bit picks negative input pins 3/2 or 0/1.
// RULE_06: Internal reference feeds both positive inputs only in mode 110.
// RULE_07: Raw comparator output is high when positive input exceeds negative input.
// RULE_08: Result bits are read-only; writes leave them alone.
// RULE_09: Pin output mode drives pins from comparators unsynchronised through a mux.
// RULE_10: Direction bits still act as output enables for both comparator pins.
// RULE_11: Change flag sets whenever either comparator output changes.
// RULE_12: Software clears the flag by writing 0 and may set it by writing 1.
// RULE_13: Interrupt needs all three enables; flag still sets without them.
// RULE_14: Mismatch against last latched value keeps setting flag until control access.
// RULE_15: A change coinciding with a control read may fail to set the flag.
// RULE_16: Comparators run during sleep; enabled change interrupt wakes the device.
// RULE_17: Mode 111 turns both comparators off.
// RULE_18: Waking from sleep leaves the control register unchanged.
// RULE_19: Reset loads zeros in bits 7-3 and ones in the mode field.
// RULE_20: Software should mask the change interrupt while changing the mode.
// RULE_21: Routing of other modes comes from a parameter table; 110 and 111 fixed. The code takes power and pin output for 110 from the table.
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module dcc_top
  import dcc_pkg::*;
#(
  parameter logic [31:0] MODE_TABLE = MODE_TABLE_DEF
) (
  input  wire logic              clock_i,
  input  wire logic              rst_n_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rdata_o,
  input  wire logic              cmp_a_raw_i,
  input  wire logic              cmp_b_raw_i,
  output logic                   cmp_a_pwr_o,
  output logic                   cmp_b_pwr_o,
  output logic                   pos_vref_o,
  output logic      [1:0]        cmp_a_neg_sel_o,
  output logic      [1:0]        cmp_b_neg_sel_o,
  input  wire logic              pin_a_latch_i,
  input  wire logic              pin_b_latch_i,
  output logic                   cmp_a_out_pin_o,
  output logic                   cmp_a_out_pin_oe_o,
  output logic                   cmp_b_out_pin_o,
  output logic                   cmp_b_out_pin_oe_o,
  input  wire logic              sleep_i,
  output logic                   irq_o,
  output logic                   wake_o
);

  // Software state
  logic [5:0]        ctrl_q;
  logic [5:0]        ctrl_d;
  logic              flag_q;
  logic              flag_d;
  logic              ena_q;
  logic              ena_d;
  logic [1:0]        irqc_q;
  logic [1:0]        irqc_d;
  logic [1:0]        dir_q;
  logic [1:0]        dir_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  // Comparator result tracking, bit 0 is A and bit 1 is B
  logic [1:0]        sync1_q;
  logic [1:0]        sync2_q;
  logic [1:0]        sync3_q;
  logic [1:0]        live_q;
  logic [1:0]        live_d;
  logic [1:0]        seen_q;
  logic [1:0]        seen_d;

  // Address decode
  wire sel_ctrl = (addr_i == OFS_CTRL);
  wire sel_flag = (addr_i == OFS_FLAG);
  wire sel_ena  = (addr_i == OFS_ENA);
  wire sel_irqc = (addr_i == OFS_IRQC);
  wire sel_dir  = (addr_i == OFS_DIR);
  wire wr_ctrl  = wr_i && sel_ctrl;
  wire wr_flag  = wr_i && sel_flag;
  wire ctrl_acc = (wr_i || rd_i) && sel_ctrl;

  // RULE_01: mode field and control bits
  wire [MODE_W-1:0] mode     = ctrl_q[MODE_W-1:0];
  wire              inv_a    = ctrl_q[BIT_A_INV];
  wire              inv_b    = ctrl_q[BIT_B_INV];
  wire              in_swap  = ctrl_q[BIT_SWITCH];
  wire              is_quad  = (mode == MODE_QUAD_VREF);
  wire              is_off   = (mode == MODE_OFF);

  // RULE_21: mode table lookup
  wire [FEAT_W-1:0] feat_raw = MODE_TABLE[{mode, 2'b00} +: FEAT_W];
  // RULE_17: mode 111 forces off
  wire [FEAT_W-1:0] feat     = is_off ? '0 : feat_raw;
  wire              pwr_a    = feat[FEAT_A_ON];
  wire              pwr_b    = feat[FEAT_B_ON];
  wire              pin_en   = feat[FEAT_PIN];

  // Analog routing
  assign cmp_a_pwr_o = pwr_a;
  assign cmp_b_pwr_o = pwr_b;
  // RULE_06: reference on positive inputs
  assign pos_vref_o = is_quad;
  // RULE_05: negative input switch
  assign cmp_a_neg_sel_o = (is_quad && in_swap) ? NEG_A_ALT : NEG_A_DEF;
  assign cmp_b_neg_sel_o = (is_quad && in_swap) ? NEG_B_ALT : NEG_B_DEF;

  // RULE_07: raw high means positive above negative; off reads low
  wire raw_a = cmp_a_raw_i && pwr_a;
  wire raw_b = cmp_b_raw_i && pwr_b;
  // RULE_04: polarity on the unsynchronised pin path
  wire pin_val_a = raw_a ^ inv_a;
  wire pin_val_b = raw_b ^ inv_b;

  // RULE_09: pins take comparator outputs straight through the mux
  assign cmp_a_out_pin_o = pin_en ? pin_val_a : pin_a_latch_i;
  assign cmp_b_out_pin_o = pin_en ? pin_val_b : pin_b_latch_i;
  // RULE_10: direction bits stay output enables, clear bit drives
  assign cmp_a_out_pin_oe_o = ~dir_q[0];
  assign cmp_b_out_pin_oe_o = ~dir_q[1];

  // Synchroniser for the register side, three stages
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      sync1_q <= 2'h0;
      sync2_q <= 2'h0;
      sync3_q <= 2'h0;
    end else begin
      sync1_q <= {cmp_b_raw_i, cmp_a_raw_i};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // Accept a level once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_live
      assign live_d[gi] = (sync2_q[gi] == sync3_q[gi]) ? sync3_q[gi] : live_q[gi];
    end
  endgenerate

  // RULE_02: B result with its polarity
  wire res_b = (live_q[1] && pwr_b) ^ inv_b;
  // RULE_03: A result with its polarity
  wire res_a = (live_q[0] && pwr_a) ^ inv_a;
  wire [1:0] res = {res_b, res_a};

  // RULE_14: mismatch against the value latched at the last access
  wire mismatch = (res != seen_q);
  assign seen_d = ctrl_acc ? res : seen_q;
  // RULE_15: a change in the access cycle is absorbed by the latch
  wire flag_set = mismatch && !ctrl_acc;

  // RULE_11: hardware set wins over software clear
  // RULE_12: software writes 0 to clear, 1 to set
  assign flag_d = flag_set || (wr_flag ? wdata_i[BIT_FLAG] : flag_q);

  // RULE_08: only the low six bits are writable
  assign ctrl_d = wr_ctrl ? wdata_i[CTRL_RW_W-1:0] : ctrl_q;
  assign ena_d  = (wr_i && sel_ena) ? wdata_i[BIT_ENA] : ena_q;
  assign irqc_d = (wr_i && sel_irqc) ? {wdata_i[BIT_GIE], wdata_i[BIT_PERIPHERAL_IRQ_EN]} : irqc_q;
  assign dir_d  = (wr_i && sel_dir) ? {wdata_i[BIT_DIR_B], wdata_i[BIT_DIR_A]} : dir_q;

  // Read multiplexer, unmapped reads return zero
  wire [DATA_W-1:0] rd_ctrl = {res_b, res_a, ctrl_q};
  wire [DATA_W-1:0] rd_flag = {1'b0, flag_q, 6'h00};
  wire [DATA_W-1:0] rd_ena  = {1'b0, ena_q, 6'h00};
  wire [DATA_W-1:0] rd_irqc = {irqc_q, 6'h00};
  wire [DATA_W-1:0] rd_dir  = {2'h0, dir_q, 4'h0};
  wire [DATA_W-1:0] rd_mux  = sel_ctrl ? rd_ctrl :
                              sel_flag ? rd_flag :
                              sel_ena  ? rd_ena  :
                              sel_irqc ? rd_irqc :
                              sel_dir  ? rd_dir  : '0;
  // Read data stands for one cycle only
  assign rdata_d = rd_i ? rd_mux : '0;
  assign rdata_o = rdata_q;

  // RULE_13: request only with all three enables
  assign irq_o = flag_q && ena_q && irqc_q[1] && irqc_q[0];
  // RULE_16: enabled change interrupt wakes a sleeping device
  assign wake_o = sleep_i && flag_q && ena_q;

  // RULE_19: reset state turns comparators off
  // RULE_18: sleep has no path into the registers
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      ctrl_q  <= CTRL_RST;
      flag_q  <= FLAG_RST;
      ena_q   <= ENA_RST;
      irqc_q  <= IRQC_RST;
      dir_q   <= DIR_RST;
      rdata_q <= '0;
      live_q  <= 2'h0;
      seen_q  <= 2'h0;
    end else begin
      ctrl_q  <= ctrl_d;
      flag_q  <= flag_d;
      ena_q   <= ena_d;
      irqc_q  <= irqc_d;
      dir_q   <= dir_d;
      rdata_q <= rdata_d;
      live_q  <= live_d;
      seen_q  <= seen_d;
    end
  end

  // Checks on the mode field
  a_mode_write_lands: assert property ( // RULE_01
    @(posedge clock_i) disable iff (!rst_n_i)
    wr_ctrl |=> (mode == $past(wdata_i[MODE_W-1:0]))
  ) else $error("mode field did not take written value");

  a_off_mode_dark: assert property ( // RULE_17
    @(posedge clock_i) disable iff (!rst_n_i)
    is_off |-> (!cmp_a_pwr_o && !cmp_b_pwr_o && !pos_vref_o)
  ) else $error("comparators powered in off mode");

  a_reset_leaves_off: assert property ( // RULE_19
    @(posedge clock_i) disable iff (!rst_n_i)
    $rose(rst_n_i) |-> (ctrl_q == CTRL_RST && !flag_q && !res_a && !res_b)
  ) else $error("reset state of control register wrong");

  // Checks on result bits and polarity
  a_b_result_read: assert property ( // RULE_02
    @(posedge clock_i) disable iff (!rst_n_i)
    (rd_i && sel_ctrl) |=>
      (rdata_o[BIT_B_RES] == (($past(live_q[1]) && $past(pwr_b)) ^ $past(inv_b)))
  ) else $error("B result bit has wrong sense");

  a_a_result_read: assert property ( // RULE_03
    @(posedge clock_i) disable iff (!rst_n_i)
    (rd_i && sel_ctrl) |=>
      (rdata_o[BIT_A_RES] == (($past(live_q[0]) && $past(pwr_a)) ^ $past(inv_a)))
  ) else $error("A result bit has wrong sense");

  a_pin_polarity: assert property ( // RULE_04
    @(posedge clock_i) disable iff (!rst_n_i)
    pin_en |-> (cmp_b_out_pin_o == ((cmp_b_raw_i && pwr_b) != inv_b))
  ) else $error("B pin polarity wrong");

  a_results_readonly: assert property ( // RULE_08
    @(posedge clock_i) disable iff (!rst_n_i)
    (wr_ctrl && wdata_i[CTRL_RW_W-1:0] == ctrl_q && live_d == live_q) |=> $stable(res)
  ) else $error("write changed result bits");

  // Checks on routing
  a_switch_route: assert property ( // RULE_05
    @(posedge clock_i) disable iff (!rst_n_i)
    (is_quad && in_swap) |-> (cmp_a_neg_sel_o == NEG_A_ALT && cmp_b_neg_sel_o == NEG_B_ALT)
  ) else $error("negative inputs not switched");

  a_vref_only_quad: assert property ( // RULE_06
    @(posedge clock_i) disable iff (!rst_n_i)
    pos_vref_o |-> (ctrl_q[MODE_W-1:0] == MODE_QUAD_VREF)
  ) else $error("reference routed outside mode 110");

  a_dir_enable: assert property ( // RULE_10
    @(posedge clock_i) disable iff (!rst_n_i)
    (wr_i && sel_dir) |=> (cmp_a_out_pin_oe_o == !$past(wdata_i[BIT_DIR_A]))
  ) else $error("direction bit not acting as enable");

  // Checks on the change flag
  a_flag_on_change: assert property ( // RULE_11
    @(posedge clock_i) disable iff (!rst_n_i)
    (mismatch && !ctrl_acc) |=> flag_q
  ) else $error("output change did not set flag");

  a_flag_sw_clear: assert property ( // RULE_12
    @(posedge clock_i) disable iff (!rst_n_i)
    (wr_flag && !wdata_i[BIT_FLAG] && !flag_set) |=> !flag_q
  ) else $error("flag not cleared by writing 0");

  a_irq_gating: assert property ( // RULE_13
    @(posedge clock_i) disable iff (!rst_n_i)
    (flag_q && !(ena_q && irqc_q[1] && irqc_q[0])) |-> !irq_o
  ) else $error("interrupt raised while disabled");

  a_access_ends: assert property ( // RULE_14
    @(posedge clock_i) disable iff (!rst_n_i)
    ctrl_acc |=> (seen_q == $past(res))
  ) else $error("control access did not latch outputs");

  a_wake_sleep: assert property ( // RULE_16
    @(posedge clock_i) disable iff (!rst_n_i)
    (sleep_i && flag_q && ena_q) |-> wake_o
  ) else $error("enabled change did not wake device");

  // Further checks on pins and routing
  a_a_pin_polarity: assert property ( // RULE_04
    @(posedge clock_i) disable iff (!rst_n_i)
    pin_en |-> (cmp_a_out_pin_o == ((cmp_a_raw_i && pwr_a) != inv_a))
  ) else $error("A pin polarity wrong");

  a_invert_bits_land: assert property ( // RULE_04
    @(posedge clock_i) disable iff (!rst_n_i)
    wr_ctrl |=> (inv_b == $past(wdata_i[BIT_B_INV]) && inv_a == $past(wdata_i[BIT_A_INV]))
  ) else $error("invert bits did not take written value");

  a_pin_latch_path: assert property ( // RULE_09
    @(posedge clock_i) disable iff (!rst_n_i)
    !pin_en |-> (cmp_a_out_pin_o == pin_a_latch_i && cmp_b_out_pin_o == pin_b_latch_i)
  ) else $error("pins not on port latches outside pin mode");

  a_b_dir_enable: assert property ( // RULE_10
    @(posedge clock_i) disable iff (!rst_n_i)
    (wr_i && sel_dir) |=> (cmp_b_out_pin_oe_o == !$past(wdata_i[BIT_DIR_B]))
  ) else $error("B direction bit not acting as enable");

  a_default_route: assert property ( // RULE_05
    @(posedge clock_i) disable iff (!rst_n_i)
    !(is_quad && in_swap) |-> (cmp_a_neg_sel_o == NEG_A_DEF && cmp_b_neg_sel_o == NEG_B_DEF)
  ) else $error("negative inputs switched outside mode 110");

  a_quad_powered: assert property ( // RULE_06
    @(posedge clock_i) disable iff (!rst_n_i)
    is_quad |-> (cmp_a_pwr_o && cmp_b_pwr_o && pos_vref_o)
  ) else $error("mode 110 lacks comparators or reference");

  a_unpowered_reads: assert property ( // RULE_07
    @(posedge clock_i) disable iff (!rst_n_i)
    (!cmp_a_pwr_o && rd_i && sel_ctrl) |=> (rdata_o[BIT_A_RES] == $past(inv_a))
  ) else $error("unpowered A result not low before inversion");

  a_off_results_low: assert property ( // RULE_17
    @(posedge clock_i) disable iff (!rst_n_i)
    (is_off && !inv_a && !inv_b) |-> (!res_a && !res_b)
  ) else $error("results high in off mode");

  // Further checks on the flag and requests
  a_flag_sticky: assert property ( // RULE_11
    @(posedge clock_i) disable iff (!rst_n_i)
    (flag_q && !wr_flag) |=> flag_q
  ) else $error("flag dropped without a clear");

  a_flag_sw_set: assert property ( // RULE_12
    @(posedge clock_i) disable iff (!rst_n_i)
    (wr_flag && wdata_i[BIT_FLAG]) |=> flag_q
  ) else $error("flag not set by writing 1");

  a_irq_all_enables: assert property ( // RULE_13
    @(posedge clock_i) disable iff (!rst_n_i)
    (flag_q && ena_q && irqc_q[1] && irqc_q[0]) |-> irq_o
  ) else $error("interrupt missing with all enables set");

  a_set_beats_clear: assert property ( // RULE_14
    @(posedge clock_i) disable iff (!rst_n_i)
    (flag_set && wr_flag && !wdata_i[BIT_FLAG]) |=> flag_q
  ) else $error("pending mismatch lost to a clear");

  a_access_no_set: assert property ( // RULE_15
    @(posedge clock_i) disable iff (!rst_n_i)
    (ctrl_acc && !flag_q && !wr_flag) |=> !flag_q
  ) else $error("flag set in a control access cycle");

  a_wake_needs_sleep: assert property ( // RULE_16
    @(posedge clock_i) disable iff (!rst_n_i)
    !sleep_i |-> !wake_o
  ) else $error("wake raised while awake");

  a_sleep_keeps_ctrl: assert property ( // RULE_18
    @(posedge clock_i) disable iff (!rst_n_i)
    !wr_ctrl |=> $stable(ctrl_q)
  ) else $error("control register changed without a write");

  a_reset_regs: assert property ( // RULE_19
    @(posedge clock_i) disable iff (!rst_n_i)
    $rose(rst_n_i) |-> (!ena_q && irqc_q == IRQC_RST && dir_q == DIR_RST && rdata_o == '0)
  ) else $error("reset state of enables or direction wrong");

endmodule

// [rtl/dcc_pkg.sv]
package dcc_pkg;
  // Register bus geometry
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;
  // Register offsets
  localparam logic [2:0] OFS_CTRL = 3'h0;
  localparam logic [2:0] OFS_FLAG = 3'h1;
  localparam logic [2:0] OFS_ENA  = 3'h2;
  localparam logic [2:0] OFS_IRQC = 3'h3;
  localparam logic [2:0] OFS_DIR  = 3'h4;
  // Control register fields
  localparam int unsigned BIT_B_RES  = 7;
  localparam int unsigned BIT_A_RES  = 6;
  localparam int unsigned BIT_B_INV  = 5;
  localparam int unsigned BIT_A_INV  = 4;
  localparam int unsigned BIT_SWITCH = 3;
  localparam int unsigned MODE_W     = 3;
  localparam int unsigned CTRL_RW_W  = 6;
  // Flag, enable and direction fields
  localparam int unsigned BIT_FLAG  = 6;
  localparam int unsigned BIT_ENA   = 6;
  localparam int unsigned BIT_GIE   = 7;
  localparam int unsigned BIT_PERIPHERAL_IRQ_EN  = 6;
  localparam int unsigned BIT_DIR_A = 4;
  localparam int unsigned BIT_DIR_B = 5;
  // Reset values
  localparam logic [5:0] CTRL_RST = 6'h07;
  localparam logic       FLAG_RST = 1'b0;
  localparam logic       ENA_RST  = 1'b0;
  localparam logic [1:0] IRQC_RST = 2'h0;
  localparam logic [1:0] DIR_RST  = 2'h3;
  // Mode encodings
  localparam logic [2:0] MODE_QUAD_VREF = 3'h6;
  localparam logic [2:0] MODE_OFF       = 3'h7;
  // Mode table feature bits, four per mode
  localparam int unsigned FEAT_W     = 4;
  localparam int unsigned FEAT_A_ON  = 0;
  localparam int unsigned FEAT_B_ON  = 1;
  localparam int unsigned FEAT_PIN   = 2;
  localparam logic [31:0] MODE_TABLE_DEF = 32'h03733373;
  // Analog pin indexes for the negative inputs
  localparam logic [1:0] NEG_A_DEF = 2'h0;
  localparam logic [1:0] NEG_B_DEF = 2'h1;
  localparam logic [1:0] NEG_A_ALT = 2'h3;
  localparam logic [1:0] NEG_B_ALT = 2'h2;
endpackage

// [test/dcc_cmp_model.sv]
`timescale 1ns/1ps
// Behavioural pair of analog comparators facing the control block
module dcc_cmp_model (
  input  wire logic clock_i,
  input  wire logic pwr_a_i,
  input  wire logic pwr_b_i,
  input  wire logic lvl_a_i,
  input  wire logic lvl_b_i,
  output logic      raw_a_o,
  output logic      raw_b_o
);
  logic junk_q = 1'b0;
  // Unpowered cores give no stable level, so show a changing pattern
  always @(posedge clock_i) junk_q <= ~junk_q;
  // high when plus input is above minus
  assign raw_a_o = pwr_a_i ? lvl_a_i : junk_q;
  assign raw_b_o = pwr_b_i ? lvl_b_i : ~junk_q;
endmodule

// [test/test_dual_comparator_control.sv]
`timescale 1ns/1ps
module test_dual_comparator_control
  import dcc_pkg::*;
;
  logic              clock_i = 1'b0;
  logic              rst_n_i = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic              wr_s = 1'b0;
  logic              rd_s = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic              raw_a, raw_b, pwr_a, pwr_b, pos_vref, lat_a = 1'b0, lat_b = 1'b0;
  logic [1:0]        sel_a, sel_b;
  logic              pin_a, oe_a, pin_b, oe_b, irq, wake;
  logic              lvl_a = 1'b0, lvl_b = 1'b0, sleep = 1'b0;
  int                errors = 0;
  int                n_checks = 0;
  // Free running system clock
  initial begin
    forever #5 clock_i = ~clock_i;
  end
  dcc_top DUT (.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata), .cmp_a_raw_i(raw_a), .cmp_b_raw_i(raw_b),
    .cmp_a_pwr_o(pwr_a), .cmp_b_pwr_o(pwr_b), .pos_vref_o(pos_vref),
    .cmp_a_neg_sel_o(sel_a), .cmp_b_neg_sel_o(sel_b), .pin_a_latch_i(lat_a),
    .pin_b_latch_i(lat_b), .cmp_a_out_pin_o(pin_a), .cmp_a_out_pin_oe_o(oe_a),
    .cmp_b_out_pin_o(pin_b), .cmp_b_out_pin_oe_o(oe_b), .sleep_i(sleep), .irq_o(irq),
    .wake_o(wake));
  dcc_cmp_model analog (.clock_i(clock_i), .pwr_a_i(pwr_a), .pwr_b_i(pwr_b),
    .lvl_a_i(lvl_a), .lvl_b_i(lvl_b), .raw_a_o(raw_a), .raw_b_o(raw_b));
  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One-cycle register write
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clock_i);
    wr_s <= 1'b0;
    #1;
  endtask
  // One-cycle read, data judged in the following cycle
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clock_i);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clock_i);
    rd_s <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic t_reset();
    rd(OFS_CTRL, 8'h07);
    rd(OFS_FLAG, 8'h00);
    rd(OFS_DIR, 8'h30);
    chk({5'h0, pos_vref, pwr_a, pwr_b}, 8'h00);
  endtask
  task automatic t_route();
    wr(OFS_CTRL, 8'hCE);
    rd(OFS_CTRL, 8'h0E);
    chk({5'h0, pos_vref, pwr_a, pwr_b}, 8'h07);
    chk({4'h0, sel_a, sel_b}, {4'h0, NEG_A_ALT, NEG_B_ALT});
    wr(OFS_CTRL, 8'h06);
    chk({4'h0, sel_a, sel_b}, {4'h0, NEG_A_DEF, NEG_B_DEF});
    wr(OFS_CTRL, 8'hC6);
    rd(OFS_CTRL, 8'h06);
  endtask
  task automatic t_change();
    int n;
    wr(OFS_ENA, 8'h40);
    wr(OFS_IRQC, 8'hC0);
    wr(OFS_FLAG, 8'h00);
    rd(OFS_FLAG, 8'h00);
    @(posedge clock_i);
    lvl_a <= 1'b1;
    n = 0;
    while (irq !== 1'b1 && n < 20) begin
      @(posedge clock_i);
      n++;
    end
    #1 chk({7'h0, irq}, 8'h01);
    rd(OFS_FLAG, 8'h40);
    rd(OFS_CTRL, 8'h46);
    wr(OFS_FLAG, 8'h00);
    rd(OFS_FLAG, 8'h00);
    chk({7'h0, irq}, 8'h00);
  endtask
  task automatic t_sleep();
    wr(OFS_FLAG, 8'h40);
    rd(OFS_FLAG, 8'h40);
    @(posedge clock_i);
    sleep <= 1'b1;
    @(posedge clock_i);
    #1 chk({6'h0, wake, irq}, 8'h03);
    wr(OFS_IRQC, 8'h80);
    chk({6'h0, wake, irq}, 8'h02);
    rd(OFS_CTRL, 8'h46);
    @(posedge clock_i);
    sleep <= 1'b0;
    wr(OFS_FLAG, 8'h00);
    chk({7'h0, wake}, 8'h00);
  endtask
  task automatic t_pins();
    wr(OFS_ENA, 8'h00);
    wr(OFS_DIR, 8'h00);
    wr(OFS_CTRL, 8'h01);
    chk({4'h0, pin_a, oe_a, pin_b, oe_b}, 8'h0D);
    wr(OFS_CTRL, 8'h31);
    chk({4'h0, pin_a, oe_a, pin_b, oe_b}, 8'h07);
    rd(OFS_CTRL, 8'hB1);
    rd(OFS_FLAG, 8'h40);
    chk({7'h0, irq}, 8'h00);
    wr(OFS_DIR, 8'h30);
    chk({6'h0, oe_a, oe_b}, 8'h00);
    @(posedge clock_i);
    lat_a <= 1'b1;
    wr(OFS_CTRL, 8'h00);
    chk({5'h0, pos_vref, pin_a, pin_b}, 8'h02);
    rd(3'h7, 8'h00);
  endtask
  // Reset in mid-run after setting every control register field
  task automatic t_rereset();
    wr(OFS_CTRL, 8'h3E);
    @(posedge clock_i);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    rst_n_i <= 1'b1;
    rd(OFS_CTRL, 8'h07);
    rd(OFS_DIR, 8'h30);
    rd(OFS_IRQC, 8'h00);
  endtask
  // Common end of run
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Watchdog well beyond the expected run
  initial begin
    #50us;
    errors++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    repeat (5) @(posedge clock_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_route();
    t_change();
    t_sleep();
    t_pins();
    t_rereset();
    report_and_stop();
  end
endmodule
